// [pkg/sqd_defines.vh]
`ifndef SQD_DEFINES_VH
`define SQD_DEFINES_VH
// Opcode fields.
`define SQD_OP_HI      23
`define SQD_OP_LO      20
`define SQD_OP_VAL     4'hf
`define SQD_SQ_HI      17
`define SQD_SQ_LO      16
`define SQD_ACC_BIT    15
`define SQD_DST_HI     14
`define SQD_DST_LO     12
`define SQD_XM_HI      9
`define SQD_XM_LO      6
`define SQD_YM_HI      5
`define SQD_YM_LO      2
`define SQD_TAIL_ED    2'h3
`define SQD_TAIL_SQ_DIFF_SUM_OP  2'h2
`define SQD_ZERO_HI    11
`define SQD_ZERO_LO    10
// Register indices.
`define SQD_REG_SQ0    4'h4
`define SQD_REG_X0     4'h8
`define SQD_REG_Y0     4'ha
`define SQD_REG_YOFS   4'hc
// Prefetch mode codes.
`define SQD_PF_IND     4'h4
`define SQD_PF_OFS     4'hc
// Accumulator limits and reset.
`define SQD_ACC_W      40
`define SQD_ACC_RST    40'h0
`define SQD_ACC_MAX    40'h7fffffffff
`define SQD_ACC_MIN    40'h8000000000
`endif

// [hdl/sqd_step.v]
`include "sqd_defines.vh"
// Decodes a prefetch mode field into a signed byte step.
module sqd_step (
	// Mode field.
	input  wire [3:0]  mode,
	// Decoded step and validity.
	output reg  [15:0] step,
	output reg         valid
);
	always @* begin
		step  = 16'h0000;
		valid = 1'b1;
		case (mode)
			4'h0: step = 16'h0002;
			4'h1: step = 16'h0004;
			4'h2: step = 16'h0006;
			4'h5: step = 16'hfffe;
			4'h6: step = 16'hfffc;
			4'h7: step = 16'hfffa;
			`SQD_PF_IND: step = 16'h0000;
			`SQD_PF_OFS: step = 16'h0000;
			default: valid = 1'b0;
		endcase
	end
endmodule

// [hdl/sqd_unit.v]
`include "sqd_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Plain op: accumulator takes square of source; Wxd takes X minus Y.
// - Summing op: accumulator adds square of source; Wxd takes X minus Y.
// - Post-modify forms add their signed step to X or Y pointer.
// - Offset form addresses Y at pointer plus offset register.
// - Plain op decodes by top nibble 1111 and tail bits 11.
// - Summing op has same layout with tail bits 10.
module sqd_unit (
	// Clock and reset.
	input  wire        REF_CLK,
	input  wire        SYS_RST,
	// Instruction issue.
	input  wire        ISSUE,
	input  wire [23:0] INSTR,
	// Register file read ports.
	input  wire [15:0] SQ_DATA,
	input  wire [15:0] XP_DATA,
	input  wire [15:0] YP_DATA,
	input  wire [15:0] YOFS_DATA,
	// Data memory operand return.
	input  wire [15:0] XMEM_DATA,
	input  wire [15:0] YMEM_DATA,
	// Register file read selects.
	output reg  [3:0]  SQ_SEL,
	output reg  [3:0]  XP_SEL,
	output reg  [3:0]  YP_SEL,
	// Data memory addresses.
	output reg         MEM_RD,
	output reg  [15:0] XMEM_ADDR,
	output reg  [15:0] YMEM_ADDR,
	// Register file write-back.
	output reg         WB_EN,
	output reg  [3:0]  WB_SEL,
	output reg  [15:0] WB_DATA,
	output reg         XP_WE,
	output reg  [15:0] XP_NEW,
	output reg         YP_WE,
	output reg  [15:0] YP_NEW,
	// Accumulators and status.
	output reg  [39:0] FIRST_ACCUM,
	output reg  [39:0] SECOND_ACCUM,
	output reg  [5:0]  STATUS,
	output reg         BUSY,
	output reg         ILLEGAL
);
	localparam ST_IDLE  = 2'h0;
	localparam ST_FETCH = 2'h1;
	localparam ST_EXEC  = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// Signed overflow test of a 40-bit sum.
	function ovf40;
		input [39:0] a;
		input [39:0] b;
		input [39:0] s;
		begin
			ovf40 = (a[39] == b[39]) && (s[39] != a[39]);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pointer index for a prefetch mode; the offset form always uses the odd pointer.
	function [3:0] ptr_sel;
		input [3:0] base;
		input [3:0] mode;
		input       alt;
		begin
			if (mode == `SQD_PF_OFS)
				ptr_sel = base + 4'h1;
			else
				ptr_sel = base + {3'h0, alt};
		end
	endfunction

	reg [1:0]  state_ff;
	reg [23:0] ins_ff;
	reg        sum_ff;
	reg [15:0] sq_ff;
	reg [15:0] xstep_ff;
	reg [15:0] ystep_ff;
	reg        xmod_ff;
	reg        ymod_ff;

	wire [15:0] xstep;
	wire [15:0] ystep;
	wire        xok;
	wire        yok;
	wire [3:0]  xm = INSTR[`SQD_XM_HI:`SQD_XM_LO];
	wire [3:0]  ym = INSTR[`SQD_YM_HI:`SQD_YM_LO];

	sqd_step u_xstep (
		.mode  (xm),
		.step  (xstep),
		.valid (xok)
	);
	sqd_step u_ystep (
		.mode  (ym),
		.step  (ystep),
		.valid (yok)
	);

	////////////////////////////////////////////////////////////////////////////
	// Decode.
	wire top_ok = INSTR[`SQD_OP_HI:`SQD_OP_LO] == `SQD_OP_VAL;
	wire is_ed  = top_ok && INSTR[1:0] == `SQD_TAIL_ED;
	wire is_sum = top_ok && INSTR[1:0] == `SQD_TAIL_SQ_DIFF_SUM_OP;
	wire x_ofs  = xm == `SQD_PF_OFS;
	wire fld_ok = xok && yok && (INSTR[`SQD_ZERO_HI:`SQD_ZERO_LO] == 2'h0);
	wire hit    = is_ed || is_sum;

	////////////////////////////////////////////////////////////////////////////
	// Square and accumulate.
	wire [31:0] sq_prod = $signed(sq_ff) * $signed(sq_ff);
	wire [39:0] sq_ext  = {{8{sq_prod[31]}}, sq_prod};
	wire        use_b   = ins_ff[`SQD_ACC_BIT];
	wire [39:0] acc_old = use_b ? SECOND_ACCUM : FIRST_ACCUM;
	wire [39:0] acc_sum = acc_old + sq_ext;
	wire        acc_ov  = sum_ff && ovf40(acc_old, sq_ext, acc_sum);
	wire [39:0] acc_sat = acc_old[39] ? `SQD_ACC_MIN : `SQD_ACC_MAX;
	wire [39:0] acc_new = sum_ff ? (acc_ov ? acc_sat : acc_sum) : sq_ext;
	wire        acc_hi  = acc_new[39:31] != {9{acc_new[31]}};

	reg [5:0] nxt_status;
	always @* begin
		nxt_status = STATUS;
		if (use_b) begin
			nxt_status[1] = acc_hi;
			nxt_status[4] = STATUS[4] | acc_ov;
		end else begin
			nxt_status[0] = acc_hi;
			nxt_status[3] = STATUS[3] | acc_ov;
		end
		nxt_status[2] = nxt_status[0] | nxt_status[1];
		nxt_status[5] = nxt_status[3] | nxt_status[4];
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer.
	// Memory data is sampled in the cycle in which MEM_RD stands high.
	always @(posedge REF_CLK) begin
		if (SYS_RST) begin
			state_ff     <= ST_IDLE;
			ins_ff       <= 24'h000000;
			sum_ff       <= 1'b0;
			sq_ff        <= 16'h0000;
			xstep_ff     <= 16'h0000;
			ystep_ff     <= 16'h0000;
			xmod_ff      <= 1'b0;
			ymod_ff      <= 1'b0;
			SQ_SEL       <= 4'h0;
			XP_SEL       <= 4'h0;
			YP_SEL       <= 4'h0;
			MEM_RD       <= 1'b0;
			XMEM_ADDR    <= 16'h0000;
			YMEM_ADDR    <= 16'h0000;
			WB_EN        <= 1'b0;
			WB_SEL       <= 4'h0;
			WB_DATA      <= 16'h0000;
			XP_WE        <= 1'b0;
			XP_NEW       <= 16'h0000;
			YP_WE        <= 1'b0;
			YP_NEW       <= 16'h0000;
			FIRST_ACCUM  <= `SQD_ACC_RST;
			SECOND_ACCUM <= `SQD_ACC_RST;
			STATUS       <= 6'h00;
			BUSY         <= 1'b0;
			ILLEGAL      <= 1'b0;
		end else begin
			MEM_RD  <= 1'b0;
			WB_EN   <= 1'b0;
			XP_WE   <= 1'b0;
			YP_WE   <= 1'b0;
			ILLEGAL <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					if (ISSUE && hit && fld_ok && !x_ofs) begin
						ins_ff   <= INSTR;
						sum_ff   <= is_sum;
						xstep_ff <= xstep;
						ystep_ff <= ystep;
						xmod_ff  <= xm != `SQD_PF_IND;
						ymod_ff  <= (ym != `SQD_PF_IND) && (ym != `SQD_PF_OFS);
						SQ_SEL   <= `SQD_REG_SQ0 + {2'h0, INSTR[`SQD_SQ_HI:`SQD_SQ_LO]};
						XP_SEL   <= ptr_sel(`SQD_REG_X0, xm, INSTR[`SQD_XM_HI + 1]);
						YP_SEL   <= ptr_sel(`SQD_REG_Y0, ym, INSTR[`SQD_YM_HI + 1]);
						BUSY     <= 1'b1;
						state_ff <= ST_FETCH;
					end else if (ISSUE && hit) begin
						ILLEGAL <= 1'b1;
					end
				end
				ST_FETCH: begin
					sq_ff     <= SQ_DATA;
					XMEM_ADDR <= XP_DATA;
					YMEM_ADDR <= (ins_ff[`SQD_YM_HI:`SQD_YM_LO] == `SQD_PF_OFS) ?
						YP_DATA + YOFS_DATA : YP_DATA;
					XP_NEW    <= XP_DATA + xstep_ff;
					YP_NEW    <= YP_DATA + ystep_ff;
					MEM_RD    <= 1'b1;
					state_ff  <= ST_EXEC;
				end
				ST_EXEC: begin
					WB_EN   <= 1'b1;
					WB_SEL  <= `SQD_REG_SQ0 + {1'b0, ins_ff[`SQD_DST_HI:`SQD_DST_LO]};
					WB_DATA <= XMEM_DATA - YMEM_DATA;
					XP_WE   <= xmod_ff;
					YP_WE   <= ymod_ff;
					if (use_b)
						SECOND_ACCUM <= acc_new;
					else
						FIRST_ACCUM <= acc_new;
					STATUS   <= nxt_status;
					BUSY     <= 1'b0;
					state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end
endmodule

// [test/sqd_unit_monitor.sv]
module sqd_mon (
	// Watched ports.
	input wire        REF_CLK,
	input wire        SYS_RST,
	input wire        ISSUE,
	input wire [23:0] INSTR,
	input wire        MEM_RD,
	input wire        WB_EN,
	input wire [3:0]  WB_SEL,
	input wire        XP_WE,
	input wire        YP_WE,
	input wire        ILLEGAL,
	input wire        BUSY,
	input wire [39:0] FIRST_ACCUM,
	input wire [39:0] SECOND_ACCUM,
	input wire [5:0]  STATUS
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	wire idle_issue = ISSUE && !BUSY;
	wire op_hit = idle_issue && INSTR[23:20] == 4'hf && INSTR[1] && INSTR[11:10] == 2'h0;
	sequence s_fetch;
		MEM_RD ##1 WB_EN;
	endsequence
	a_fetch_then_wb: assert property ($rose(BUSY) |=> s_fetch) else $error("fetch order");
	a_dest_range: assert property (WB_EN |-> WB_SEL[3:2] == 2'h1) else $error("dest");
	a_ptr_with_wb: assert property (XP_WE || YP_WE |-> WB_EN) else $error("ptr write");
	a_illegal_quiet: assert property (ILLEGAL |=> !MEM_RD [*3]) else $error("refused ran");
	a_acc_hold: assert property (!WB_EN |-> $stable(FIRST_ACCUM) && $stable(SECOND_ACCUM))
		else $error("acc moved");
	a_opcode_taken: assert property (op_hit |=> BUSY != ILLEGAL) else $error("not taken");
	a_foreign_skip: assert property (idle_issue && INSTR[23:20] != 4'hf |=> !BUSY && !ILLEGAL)
		else $error("foreign taken");
	a_ovf_flag: assert property (STATUS[0] == !(&FIRST_ACCUM[39:31] || ~|FIRST_ACCUM[39:31]))
		else $error("ovf flag");
endmodule
bind sqd_unit sqd_mon u_mon (.REF_CLK, .SYS_RST, .ISSUE, .INSTR, .MEM_RD, .WB_EN, .WB_SEL, .XP_WE,
	.YP_WE, .ILLEGAL, .BUSY, .FIRST_ACCUM, .SECOND_ACCUM, .STATUS);

// [test/sqd_mem_model.sv]
module sqd_mem (
	// Bus side.
	input wire          clk,
	input wire          rd,
	input wire   [15:0] xa,
	input wire   [15:0] ya,
	output logic [15:0] xd,
	output logic [15:0] yd
);
	timeunit 1ns;
	timeprecision 1ps;
	// Data stands while the read strobe is high and shows its inverse otherwise.
	always_comb begin
		xd = rd ? (xa ^ 16'h3c3c) : ~(xa ^ 16'h3c3c);
		yd = rd ? (ya + 16'h1357) : ~(ya + 16'h1357);
	end
endmodule

// [test/sqd_unit_tb.sv]
module sqd_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 0, sys_rst = 1, issue = 0;
	logic [23:0] instr = 0;
	logic [15:0] sq = 0, xp = 0, yp = 0, yo = 0;
	logic [39:0] ea = 0, eb = 0;
	logic        esa = 0, esb = 0, big_sq = 0;
	logic [3:0]  mt [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'hc};
	wire  [15:0] xd, yd, xa, ya, wbd, xn, yn;
	wire  [39:0] fa, sa;
	wire  [3:0]  wbs, sqs, xps, yps;
	wire  [5:0]  st;
	wire         rd, wb, xw, yw, ill, busy;
	int          error_cnt = 0, total_checks = 0;
	sqd_unit uut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .ISSUE(issue), .INSTR(instr), .SQ_DATA(sq),
		.XP_DATA(xp), .YP_DATA(yp), .YOFS_DATA(yo), .XMEM_DATA(xd), .YMEM_DATA(yd),
		.SQ_SEL(sqs), .XP_SEL(xps), .YP_SEL(yps), .MEM_RD(rd), .XMEM_ADDR(xa), .YMEM_ADDR(ya),
		.WB_EN(wb), .WB_SEL(wbs), .WB_DATA(wbd), .XP_WE(xw), .XP_NEW(xn), .YP_WE(yw), .YP_NEW(yn),
		.FIRST_ACCUM(fa), .SECOND_ACCUM(sa), .STATUS(st), .BUSY(busy), .ILLEGAL(ill));
	sqd_mem mem (.clk(ref_clk), .rd(rd), .xa(xa), .ya(ya), .xd(xd), .yd(yd));
	always #5 ref_clk = ~ref_clk;
	task chk(input logic [39:0] g, e);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	function logic [15:0] pm(input logic [15:0] p, input logic [3:0] m);
		if (m[2:0] == 3'h4)
			return p;
		return p + (m[2] ? -{13'h0, m[1:0], 1'b0} : {13'h0, m[1:0] + 2'h1, 1'b0});
	endfunction
	function logic sat(input logic [39:0] a, input logic [15:0] s, input logic add);
		logic signed [39:0] v;
		v = $signed(s);
		v = v * v;
		return add && !a[39] && (a + v) >= 40'h8000000000;
	endfunction
	function logic [39:0] acc(input logic [39:0] a, input logic [15:0] s, input logic add);
		logic signed [39:0] v;
		v = $signed(s);
		v = v * v;
		if (sat(a, s, add))
			return 40'h7fffffffff;
		return add ? a + v : v;
	endfunction
	function logic ov(input logic [39:0] a);
		return a[39:31] != {9{a[31]}};
	endfunction
	function logic [23:0] mk(input logic [3:0] x, y, input logic t);
		return {4'hf, 2'h0, 2'($urandom), 1'($urandom), 1'b0, 2'($urandom), 2'h0, x, y, 1'b1, t};
	endfunction
	task op(input logic [23:0] i, input logic bad);
		logic        il, w, xwv, ywv;
		logic [15:0] xnv, ynv, ey;
		sq = big_sq ? 16'h8000 : 16'($urandom);
		xp = $urandom;
		yp = $urandom;
		yo = $urandom;
		issue = 1;
		instr = i;
		@(posedge ref_clk);
		#1;
		issue = 0;
		il = ill;
		w = 0;
		xwv = 0;
		ywv = 0;
		xnv = 0;
		ynv = 0;
		repeat (3) begin
			@(posedge ref_clk);
			#1;
			il |= ill;
			w |= wb;
			if (wb) begin
				xwv = xw;
				xnv = xn;
				ywv = yw;
				ynv = yn;
			end
		end
		chk(il, bad);
		chk(w, !bad);
		if (!bad) begin
			if (i[15]) begin
				esb |= sat(eb, sq, !i[0]);
				eb = acc(eb, sq, !i[0]);
			end else begin
				esa |= sat(ea, sq, !i[0]);
				ea = acc(ea, sq, !i[0]);
			end
			ey = (i[5:2] == 4'hc) ? yp + yo : yp;
			chk(wbs, {2'h1, i[13:12]});
			chk(sqs, {2'h1, i[17:16]});
			chk(xps, 4'h8);
			chk(yps, {3'h5, i[5:2] == 4'hc ? 1'b1 : i[6]});
			chk(wbd, 16'((xp ^ 16'h3c3c) - 16'(ey + 16'h1357)));
			chk({xwv, xnv}, {i[8:6] != 3'h4, pm(xp, i[9:6])});
			chk({ywv, ynv}, {i[4:2] != 3'h4, pm(yp, i[5:2])});
		end
		chk(fa, ea);
		chk(sa, eb);
		chk(st, {esa | esb, esb, esa, ov(ea) | ov(eb), ov(eb), ov(ea)});
	endtask
	task stop_test;
		$display("Checks %0d, errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hc566));
		repeat (12) @(posedge ref_clk);
		#1;
		sys_rst = 0;
		@(posedge ref_clk);
		#1;
		for (int k = 0; k < 8; k++)
			op(mk(k < 7 ? mt[k] : 4'h4, mt[k], k[0]), 0);
		op(mk(4'hc, 4'h0, 1'b1), 1);
		op(mk(4'h3, 4'h1, 1'b0), 1);
		op(mk(4'h0, 4'hb, 1'b1), 1);
		instr = 24'he00003;
		issue = 1;
		@(posedge ref_clk);
		#1;
		issue = 0;
		chk({busy, ill}, 2'h0);
		@(posedge ref_clk);
		#1;
		repeat (200)
			op(mk(mt[$urandom % 7], mt[$urandom % 8], 1'($urandom)), 0);
		big_sq = 1;
		repeat (520)
			op(mk(4'h0, 4'h5, 1'b0) & 24'hff7fff, 0);
		big_sq = 0;
		sys_rst = 1;
		repeat (2) @(posedge ref_clk);
		#1;
		sys_rst = 0;
		{ea, eb, esa, esb} = '0;
		chk({fa, sa}, {ea, eb});
		chk(st, 6'h00);
		repeat (8)
			op(mk(mt[$urandom % 7], mt[$urandom % 8], 1'($urandom)), 0);
		stop_test();
	end
	initial begin
		#80000;
		error_cnt++;
		stop_test();
	end
endmodule
